// File: rtl/iga_cfg.svh
`ifndef IGA_CFG_SVH
`define IGA_CFG_SVH
// Notes on behaviour
// - Left amp powered when its own enable or the left path enable is set.
// - Right amp powered when its own enable or the right path enable is set.
// - Power register: left path enable bit 5, right bit 4, both reset 0.
// - Amp control bits 3..0 connect pins 1..4; pin 1 resets on, others off.
// - Each amp has its own 6-bit gain, code zero gives the least gain.
// - Gain code in bits 5:0, reset 011111 (0dB), 111111 is the most gain.
// - Silence bit 7 in each volume register, reset 1, 1 silences the amp.
// - Zero-cross gate bit 6, reset 0; 0 applies at once, 1 waits for crossing.
// - With the gate on, a pending gain change waits for that path's crossing.
// - With the gate on, the timeout tick applies a change if no crossing came.
// - A volume write with update bit 0 stores the code, silence and gate bits; gate 0 releases a waiting change.
// - Writing update 1 to either volume register applies both gain codes.
// - Both silence settings take effect only on an update write.
// - Update trigger is write-only bit 8 of both volume registers.

// Register offsets
`define IGA_OFF_LVOL     8'h00
`define IGA_OFF_RVOL     8'h01
`define IGA_OFF_PWR      8'h19
`define IGA_OFF_LAMP     8'h25
`define IGA_OFF_RAMP     8'h26
`define IGA_OFF_TICK     8'h30
`define IGA_OFF_STAT     8'h31
// Volume register fields
`define IGA_B_UPDATE     8
`define IGA_B_SILENCE    7
`define IGA_B_ZC         6
`define IGA_CODE_HI      5
`define IGA_CODE_LO      0
`define IGA_CODE_RST     6'h1F
`define IGA_SILENCE_RST  1'h1
`define IGA_ZC_RST       1'h0
// Power and amp control fields
`define IGA_B_LPATH      5
`define IGA_B_RPATH      4
`define IGA_B_AMPPWR     4
`define IGA_PIN_HI       3
`define IGA_PIN_LO       0
`define IGA_PIN_RST      4'h8
`define IGA_PWR_RST      1'h0
// Timeout tick control fields
`define IGA_B_TICK_EN    0
`define IGA_TDIV_HI      3
`define IGA_TDIV_LO      1
`define IGA_TDIV_RST     3'h0
// Timing
`define IGA_CLK_NS       25
`define IGA_TBASE_NS     1600
`define IGA_TBASE_CYC    ((`IGA_TBASE_NS) / (`IGA_CLK_NS))
`endif

// File: rtl/iga_pkg.sv
package iga_pkg;
	typedef enum logic [1:0] {
		IGA_ST_IDLE = 2'h1,
		IGA_ST_WAIT = 2'h2
	} iga_side_state_t;

	typedef struct packed {
		iga_side_state_t st;
		logic [5:0]      held_code;
		logic            held_silence;
		logic [5:0]      code;
		logic            silence;
	} iga_side_reg_t;

	typedef struct packed {
		logic [5:0]  lcode;
		logic        lsil;
		logic        lzc;
		logic [5:0]  rcode;
		logic        rsil;
		logic        rzc;
		logic        lpath;
		logic        rpath;
		logic        lamp;
		logic [3:0]  lpins;
		logic        ramp;
		logic [3:0]  rpins;
		logic        tick_en;
		logic [2:0]  tick_div;
		logic [15:0] tcnt;
		logic        tick;
		logic        upd;
		logic        zl_s1;
		logic        zl_s2;
		logic        zl_s3;
		logic        zr_s1;
		logic        zr_s2;
		logic        zr_s3;
		logic        zl_ev;
		logic        zr_ev;
		logic        lpow;
		logic        rpow;
		logic [15:0] rdata;
	} iga_top_reg_t;
endpackage : iga_pkg

// File: rtl/iga_side_if.sv
interface iga_side_if;
	logic       update;
	logic       zc_enable;
	logic       zero_cross;
	logic       timeout;
	logic [5:0] staged_code;
	logic       staged_silence;
	logic [5:0] active_code;
	logic       active_silence;
	logic       pending;

	modport ctl (
		output update, zc_enable, zero_cross, timeout, staged_code, staged_silence,
		input  active_code, active_silence, pending
	);
	modport side (
		input  update, zc_enable, zero_cross, timeout, staged_code, staged_silence,
		output active_code, active_silence, pending
	);
endinterface : iga_side_if

// File: rtl/iga_side_apply.sv
`include "iga_cfg.svh"

module iga_side_apply (
	input wire logic clk_in,   // System clock
	input wire logic rst_n_in, // Synchronous reset, active low
	iga_side_if.side sb        // Staged values in, active values out
);
	import iga_pkg::*;

	localparam iga_side_reg_t SIDE_RST = '{
		st:           IGA_ST_IDLE,
		held_code:    `IGA_CODE_RST,
		held_silence: `IGA_SILENCE_RST,
		code:         `IGA_CODE_RST,
		silence:      `IGA_SILENCE_RST
	};

	iga_side_reg_t r;
	iga_side_reg_t next_r;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		case (r.st)
			IGA_ST_IDLE: begin
				if (sb.update) begin
					next_r.held_code    = sb.staged_code;
					next_r.held_silence = sb.staged_silence;
					if (sb.zc_enable) begin
						next_r.st = IGA_ST_WAIT;
					end else begin
						next_r.code    = sb.staged_code;
						next_r.silence = sb.staged_silence;
					end
				end
			end
			IGA_ST_WAIT: begin
				// A fresh update replaces what is still waiting
				if (sb.update) begin
					next_r.held_code    = sb.staged_code;
					next_r.held_silence = sb.staged_silence;
				end
				// Gate cleared while waiting releases the change at once
				if (sb.zero_cross || sb.timeout || !sb.zc_enable) begin
					next_r.code    = next_r.held_code;
					next_r.silence = next_r.held_silence;
					next_r.st      = IGA_ST_IDLE;
				end
			end
			default: begin
				next_r = SIDE_RST;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			r <= SIDE_RST;
		end else begin
			r <= next_r;
		end
	end

	assign sb.active_code    = r.code;
	assign sb.active_silence = r.silence;
	assign sb.pending        = (r.st == IGA_ST_WAIT);
endmodule : iga_side_apply

// File: rtl/iga_top.sv
// Our own choice: the strobed register port.
`include "iga_cfg.svh"

module iga_top #(
	parameter int TICK_BASE_CYC = `IGA_TBASE_CYC  // Timeout tick base period in clocks
) (
	input  wire logic        MCLK_IN,               // System clock, 40 MHz
	input  wire logic        RSTN_IN,               // Synchronous reset, active low
	input  wire logic [7:0]  ADDR_IN,               // Register address
	input  wire logic [15:0] WDATA_IN,              // Write data
	input  wire logic        WR_IN,                 // Write strobe
	input  wire logic        RD_IN,                 // Read strobe
	input  wire logic        ZC_LEFT_IN,            // Left path signal polarity
	input  wire logic        ZC_RIGHT_IN,           // Right path signal polarity
	output logic      [15:0] RDATA_OUT,             // Read data, one cycle after strobe
	output logic             LEFT_AMP_POWER_OUT,    // Left amplifier powered
	output logic             RIGHT_AMP_POWER_OUT,   // Right amplifier powered
	output logic             LEFT_MIXER_POWER_OUT,  // Left input mixer powered
	output logic             RIGHT_MIXER_POWER_OUT, // Right input mixer powered
	output logic      [3:0]  LEFT_PIN_SELECT_OUT,   // Left pins 1..4 at bits 3..0
	output logic      [3:0]  RIGHT_PIN_SELECT_OUT,  // Right pins 1..4 at bits 3..0
	output logic      [5:0]  LEFT_GAIN_CODE_OUT,    // Applied left gain code
	output logic      [5:0]  RIGHT_GAIN_CODE_OUT,   // Applied right gain code
	output logic             LEFT_SILENCE_OUT,      // Applied left mute
	output logic             RIGHT_SILENCE_OUT      // Applied right mute
);
	import iga_pkg::*;

	localparam iga_top_reg_t TOP_RST = '{
		lcode:    `IGA_CODE_RST,
		lsil:     `IGA_SILENCE_RST,
		lzc:      `IGA_ZC_RST,
		rcode:    `IGA_CODE_RST,
		rsil:     `IGA_SILENCE_RST,
		rzc:      `IGA_ZC_RST,
		lpath:    `IGA_PWR_RST,
		rpath:    `IGA_PWR_RST,
		lamp:     `IGA_PWR_RST,
		lpins:    `IGA_PIN_RST,
		ramp:     `IGA_PWR_RST,
		rpins:    `IGA_PIN_RST,
		tick_en:  1'h0,
		tick_div: `IGA_TDIV_RST,
		tcnt:     16'h0000,
		tick:     1'h0,
		upd:      1'h0,
		zl_s1:    1'h0,
		zl_s2:    1'h0,
		zl_s3:    1'h0,
		zr_s1:    1'h0,
		zr_s2:    1'h0,
		zr_s3:    1'h0,
		zl_ev:    1'h0,
		zr_ev:    1'h0,
		lpow:     1'h0,
		rpow:     1'h0,
		rdata:    16'h0000
	};

	iga_top_reg_t r;
	iga_top_reg_t next_r;

	iga_side_if lif ();
	iga_side_if rif ();

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Readback of a volume register; the update bit reads as zero
	function automatic logic [15:0] vol_read(
		input logic       sil,
		input logic       zc,
		input logic [5:0] code
	);
		logic [15:0] v;
		v = 16'h0000;
		v[`IGA_B_SILENCE] = sil;
		v[`IGA_B_ZC] = zc;
		v[`IGA_CODE_HI:`IGA_CODE_LO] = code;
		return v;
	endfunction : vol_read

	// Readback of an amplifier control register
	function automatic logic [15:0] amp_read(
		input logic       en,
		input logic [3:0] pins
	);
		logic [15:0] v;
		v = 16'h0000;
		v[`IGA_B_AMPPWR] = en;
		v[`IGA_PIN_HI:`IGA_PIN_LO] = pins;
		return v;
	endfunction : amp_read

	// Timeout period in clocks: base period doubled per divider step
	function automatic logic [15:0] tick_limit(
		input logic [2:0] div
	);
		return 16'(TICK_BASE_CYC) << div;
	endfunction : tick_limit

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_r       = r;
		next_r.rdata = 16'h0000;
		next_r.tick  = 1'h0;
		next_r.upd   = 1'h0;

		// Polarity inputs cross in over two flip-flops, third stage finds edges
		next_r.zl_s1 = ZC_LEFT_IN;
		next_r.zl_s2 = r.zl_s1;
		next_r.zl_s3 = r.zl_s2;
		next_r.zr_s1 = ZC_RIGHT_IN;
		next_r.zr_s2 = r.zr_s1;
		next_r.zr_s3 = r.zr_s2;
		next_r.zl_ev = r.zl_s2 ^ r.zl_s3;
		next_r.zr_ev = r.zr_s2 ^ r.zr_s3;

		// Timeout tick divider
		if (!r.tick_en) begin
			next_r.tcnt = 16'h0000;
		end else if (r.tcnt >= tick_limit(r.tick_div) - 16'h0001) begin
			next_r.tcnt = 16'h0000;
			next_r.tick = 1'h1;
		end else begin
			next_r.tcnt = r.tcnt + 16'h0001;
		end

		// Register writes
		if (WR_IN) begin
			case (ADDR_IN)
				`IGA_OFF_LVOL: begin
					next_r.lcode = WDATA_IN[`IGA_CODE_HI:`IGA_CODE_LO];
					next_r.lsil  = WDATA_IN[`IGA_B_SILENCE];
					next_r.lzc   = WDATA_IN[`IGA_B_ZC];
					next_r.upd   = WDATA_IN[`IGA_B_UPDATE];
				end
				`IGA_OFF_RVOL: begin
					next_r.rcode = WDATA_IN[`IGA_CODE_HI:`IGA_CODE_LO];
					next_r.rsil  = WDATA_IN[`IGA_B_SILENCE];
					next_r.rzc   = WDATA_IN[`IGA_B_ZC];
					next_r.upd   = WDATA_IN[`IGA_B_UPDATE];
				end
				`IGA_OFF_PWR: begin
					next_r.lpath = WDATA_IN[`IGA_B_LPATH];
					next_r.rpath = WDATA_IN[`IGA_B_RPATH];
				end
				`IGA_OFF_LAMP: begin
					next_r.lamp  = WDATA_IN[`IGA_B_AMPPWR];
					next_r.lpins = WDATA_IN[`IGA_PIN_HI:`IGA_PIN_LO];
				end
				`IGA_OFF_RAMP: begin
					next_r.ramp  = WDATA_IN[`IGA_B_AMPPWR];
					next_r.rpins = WDATA_IN[`IGA_PIN_HI:`IGA_PIN_LO];
				end
				`IGA_OFF_TICK: begin
					next_r.tick_en  = WDATA_IN[`IGA_B_TICK_EN];
					next_r.tick_div = WDATA_IN[`IGA_TDIV_HI:`IGA_TDIV_LO];
				end
				default: begin
				end
			endcase
		end

		// Amplifier power follows its own enable or the path enable
		next_r.lpow = next_r.lamp | next_r.lpath;
		next_r.rpow = next_r.ramp | next_r.rpath;

		// Register reads; unmapped addresses read as zero
		if (RD_IN) begin
			case (ADDR_IN)
				`IGA_OFF_LVOL: begin
					next_r.rdata = vol_read(r.lsil, r.lzc, r.lcode);
				end
				`IGA_OFF_RVOL: begin
					next_r.rdata = vol_read(r.rsil, r.rzc, r.rcode);
				end
				`IGA_OFF_PWR: begin
					next_r.rdata[`IGA_B_LPATH] = r.lpath;
					next_r.rdata[`IGA_B_RPATH] = r.rpath;
				end
				`IGA_OFF_LAMP: begin
					next_r.rdata = amp_read(r.lamp, r.lpins);
				end
				`IGA_OFF_RAMP: begin
					next_r.rdata = amp_read(r.ramp, r.rpins);
				end
				`IGA_OFF_TICK: begin
					next_r.rdata[`IGA_B_TICK_EN] = r.tick_en;
					next_r.rdata[`IGA_TDIV_HI:`IGA_TDIV_LO] = r.tick_div;
				end
				`IGA_OFF_STAT: begin
					next_r.rdata[0] = lif.pending;
					next_r.rdata[1] = rif.pending;
					next_r.rdata[2] = lif.active_silence;
					next_r.rdata[3] = rif.active_silence;
					next_r.rdata[4] = r.lpow;
					next_r.rdata[5] = r.rpow;
				end
				default: begin
					next_r.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!RSTN_IN) begin
			r <= TOP_RST;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Staged to active per side; one update reaches both sides together

	assign lif.update         = r.upd;
	assign lif.zc_enable      = r.lzc;
	assign lif.zero_cross     = r.zl_ev;
	assign lif.timeout        = r.tick;
	assign lif.staged_code    = r.lcode;
	assign lif.staged_silence = r.lsil;

	assign rif.update         = r.upd;
	assign rif.zc_enable      = r.rzc;
	assign rif.zero_cross     = r.zr_ev;
	assign rif.timeout        = r.tick;
	assign rif.staged_code    = r.rcode;
	assign rif.staged_silence = r.rsil;

	iga_side_apply u_left (
		.clk_in   (MCLK_IN),
		.rst_n_in (RSTN_IN),
		.sb       (lif.side)
	);

	iga_side_apply u_right (
		.clk_in   (MCLK_IN),
		.rst_n_in (RSTN_IN),
		.sb       (rif.side)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign RDATA_OUT             = r.rdata;
	assign LEFT_AMP_POWER_OUT    = r.lpow;
	assign RIGHT_AMP_POWER_OUT   = r.rpow;
	assign LEFT_MIXER_POWER_OUT  = r.lpath;
	assign RIGHT_MIXER_POWER_OUT = r.rpath;
	assign LEFT_PIN_SELECT_OUT   = r.lpins;
	assign RIGHT_PIN_SELECT_OUT  = r.rpins;
	assign LEFT_GAIN_CODE_OUT    = lif.active_code;
	assign RIGHT_GAIN_CODE_OUT   = rif.active_code;
	assign LEFT_SILENCE_OUT      = lif.active_silence;
	assign RIGHT_SILENCE_OUT     = rif.active_silence;
endmodule : iga_top

// File: sim/iga_top_chk.sv
module iga_top_chk #(
	parameter int TICK_BASE_CYC = 64  // Timeout tick base period in clocks
) (
	input wire logic        MCLK_IN,               // Clock
	input wire logic        RSTN_IN,               // Reset, active low
	input wire logic [7:0]  ADDR_IN,               // Address
	input wire logic [15:0] WDATA_IN,              // Write data
	input wire logic        WR_IN,                 // Write strobe
	input wire logic        RD_IN,                 // Read strobe
	input wire logic [15:0] RDATA_OUT,             // Read data
	input wire logic        LEFT_AMP_POWER_OUT,    // Left amp power
	input wire logic        RIGHT_AMP_POWER_OUT,   // Right amp power
	input wire logic        LEFT_MIXER_POWER_OUT,  // Left mixer power
	input wire logic        RIGHT_MIXER_POWER_OUT, // Right mixer power
	input wire logic [3:0]  LEFT_PIN_SELECT_OUT,   // Left pins
	input wire logic [5:0]  LEFT_GAIN_CODE_OUT,    // Left applied gain
	input wire logic [5:0]  RIGHT_GAIN_CODE_OUT,   // Right applied gain
	input wire logic        LEFT_SILENCE_OUT       // Left applied mute
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RSTN_IN);

	////////////////////////////////////////////////////////////////////////////////
	a_read_idle_zero: assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
		else $error("read data not zero outside read answer");
	a_unmapped_read_zero: assert property (RD_IN && ADDR_IN == 8'h02 |=> RDATA_OUT == 16'h0000)
		else $error("unmapped read not zero");
	a_update_reads_zero: assert property (RD_IN && ADDR_IN[7:1] == 7'h00 |=> RDATA_OUT[15:8] == 8'h00)
		else $error("update trigger reads back nonzero");
	a_path_power_write: assert property (WR_IN && ADDR_IN == 8'h19 |=>
		LEFT_MIXER_POWER_OUT == $past(WDATA_IN[5]) && RIGHT_MIXER_POWER_OUT == $past(WDATA_IN[4]))
		else $error("path power does not follow write");
	a_left_amp_or: assert property (LEFT_MIXER_POWER_OUT |-> LEFT_AMP_POWER_OUT)
		else $error("left amp off while path on");
	a_right_amp_or: assert property (RIGHT_MIXER_POWER_OUT |-> RIGHT_AMP_POWER_OUT)
		else $error("right amp off while path on");
	a_amp_enable_write: assert property (WR_IN && ADDR_IN == 8'h25 && WDATA_IN[4] |=> LEFT_AMP_POWER_OUT)
		else $error("left amp enable not applied");
	a_pin_select_write: assert property (WR_IN && ADDR_IN == 8'h25 |=>
		LEFT_PIN_SELECT_OUT == $past(WDATA_IN[3:0]))
		else $error("left pin select does not follow write");
	a_left_apply_now: assert property (WR_IN && ADDR_IN == 8'h00 && WDATA_IN[8] && !WDATA_IN[6] |-> ##2
		LEFT_GAIN_CODE_OUT == $past(WDATA_IN[5:0], 2) && LEFT_SILENCE_OUT == $past(WDATA_IN[7], 2))
		else $error("left update not applied after two cycles");
	a_right_apply_now: assert property (WR_IN && ADDR_IN == 8'h01 && WDATA_IN[8] && !WDATA_IN[6] |-> ##2
		RIGHT_GAIN_CODE_OUT == $past(WDATA_IN[5:0], 2))
		else $error("right update not applied after two cycles");
	c_update_write: cover property (WR_IN && ADDR_IN[7:1] == 7'h00 && WDATA_IN[8]);
	c_power_read: cover property (RD_IN && ADDR_IN == 8'h19);
	c_gain_change: cover property ($changed(LEFT_GAIN_CODE_OUT));
endmodule : iga_top_chk

bind iga_top iga_top_chk #(.TICK_BASE_CYC(TICK_BASE_CYC)) iga_top_chk_i (
	.MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
	.WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
	.LEFT_AMP_POWER_OUT(LEFT_AMP_POWER_OUT), .RIGHT_AMP_POWER_OUT(RIGHT_AMP_POWER_OUT),
	.LEFT_MIXER_POWER_OUT(LEFT_MIXER_POWER_OUT), .RIGHT_MIXER_POWER_OUT(RIGHT_MIXER_POWER_OUT),
	.LEFT_PIN_SELECT_OUT(LEFT_PIN_SELECT_OUT), .LEFT_GAIN_CODE_OUT(LEFT_GAIN_CODE_OUT),
	.RIGHT_GAIN_CODE_OUT(RIGHT_GAIN_CODE_OUT), .LEFT_SILENCE_OUT(LEFT_SILENCE_OUT)
);

// File: sim/iga_top_tb.sv
module iga_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import iga_pkg::*;
	logic        mclk, rstn, wr, rd, zcl, zcr;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata;
	logic        lamp, ramp, lmix, rmix, lsil, rsil;
	logic [3:0]  lpin, rpin;
	logic [5:0]  lgain, rgain;
	int          n_errors, samples_checked, cycles;

	iga_top #(.TICK_BASE_CYC(4)) iga_top_i (
		.MCLK_IN(mclk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
		.RD_IN(rd), .ZC_LEFT_IN(zcl), .ZC_RIGHT_IN(zcr), .RDATA_OUT(rdata),
		.LEFT_AMP_POWER_OUT(lamp), .RIGHT_AMP_POWER_OUT(ramp),
		.LEFT_MIXER_POWER_OUT(lmix), .RIGHT_MIXER_POWER_OUT(rmix),
		.LEFT_PIN_SELECT_OUT(lpin), .RIGHT_PIN_SELECT_OUT(rpin),
		.LEFT_GAIN_CODE_OUT(lgain), .RIGHT_GAIN_CODE_OUT(rgain),
		.LEFT_SILENCE_OUT(lsil), .RIGHT_SILENCE_OUT(rsil)
	);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Cuts a hang short
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		// Look after the edge's updates have settled
		#1;
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : chk_reg

	// Applied mutes and gains: left mute, right mute, left code, right code
	task automatic gains(input logic [13:0] e);
		chk({2'h0, lsil, rsil, lgain, rgain}, {2'h0, e});
	endtask : gains

	task automatic pwr(input logic [3:0] e);
		chk({12'h0, lamp, ramp, lmix, rmix}, {12'h0, e});
	endtask : pwr

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({8'h0, lpin, rpin}, 16'h0088);
		pwr(4'h0);
		gains(14'h37DF);
		chk_reg(8'h00, 16'h009F);
		chk_reg(8'h01, 16'h009F);
		chk_reg(8'h19, 16'h0000);
		chk_reg(8'h25, 16'h0008);
		chk_reg(8'h26, 16'h0008);
		chk_reg(8'h02, 16'h0000);
	endtask : t_reset

	task automatic t_power();
		wr_reg(8'h19, 16'h0020);
		cyc(2);
		pwr(4'hA);
		wr_reg(8'h19, 16'h0010);
		cyc(2);
		pwr(4'h5);
		wr_reg(8'h25, 16'h0018);
		wr_reg(8'h19, 16'h0000);
		cyc(2);
		pwr(4'h8);
		wr_reg(8'h26, 16'h0018);
		cyc(2);
		pwr(4'hC);
		chk_reg(8'h19, 16'h0000);
	endtask : t_power

	task automatic t_pins();
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'h25, 16'(1 << i));
			wr_reg(8'h26, 16'(8 >> i));
			cyc(2);
			chk({8'h0, lpin, rpin}, {8'h0, 4'(1 << i), 4'(8 >> i)});
			chk_reg(8'h26, 16'(8 >> i));
		end
	endtask : t_pins

	task automatic t_staged();
		wr_reg(8'h00, 16'h0000);
		wr_reg(8'h01, 16'h003F);
		cyc(3);
		gains(14'h37DF);
		chk_reg(8'h00, 16'h0000);
		wr_reg(8'h01, 16'h013F);
		cyc(3);
		gains(14'h003F);
		chk_reg(8'h01, 16'h003F);
		wr_reg(8'h00, 16'h01A5);
		cyc(3);
		gains(14'h297F);
	endtask : t_staged

	task automatic t_zero_cross();
		wr_reg(8'h00, 16'h0050);
		wr_reg(8'h01, 16'h0120);
		cyc(3);
		gains(14'h2960);
		cyc(20);
		gains(14'h2960);
		@(posedge mclk);
		zcl <= ~zcl;
		zcr <= ~zcr;
		cyc(8);
		gains(14'h0420);
	endtask : t_zero_cross

	task automatic t_timeout();
		wr_reg(8'h30, 16'h0003);
		wr_reg(8'h00, 16'h0157);
		cyc(2);
		gains(14'h0420);
		chk_reg(8'h31, 16'h0001);
		cyc(30);
		gains(14'h05E0);
	endtask : t_timeout

	task automatic results();
		$display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	initial begin
		rstn  = 1'b0;
		wr    = 1'b0;
		rd    = 1'b0;
		zcl   = 1'b0;
		zcr   = 1'b0;
		addr  = 8'h00;
		wdata = 16'h0000;
		cycles = 0;
		cyc(12);
		rstn <= 1'b1;
		t_reset();
		t_power();
		t_pins();
		t_staged();
		t_zero_cross();
		t_timeout();
		results();
	end
endmodule : iga_top_tb
